// >>> icds_cfg.svh
// constants of the input clock divider and alignment block
`ifndef ICDS_CFG_SVH
`define ICDS_CFG_SVH
`define ICDS_ADDR_W 10
`define ICDS_ALIGN_OFS 10'h109
`define ICDS_RATIO_OFS 10'h10b
`define ICDS_STAB_OFS 10'h10c
`define ICDS_STAT_OFS 10'h10d
`define ICDS_ALIGN_RST 8'h00
`define ICDS_RATIO_RST 8'h00
`define ICDS_STAB_RST 8'h01
`define ICDS_ALIGN_EN_BIT 0
`define ICDS_ALIGN_FIRST_BIT 1
`define ICDS_ALIGN_SYSREF_BIT 7
`define ICDS_CLK_NS 40
`define ICDS_RELOCK_NS 1500
`define ICDS_RELOCK_MAX_NS 5000
`endif

// >>> icds_pkg.sv
// types of the input clock divider and alignment block
package icds_pkg;
  typedef struct packed {
    logic sysref_sel;
    logic [4:0] rsv;
    logic first_only;
    logic sync_en;
  } icds_align_t;
  typedef struct packed {
    logic [3:0] rsv;
    logic locked;
    logic armed;
    logic conv_clk;
    logic stab_en;
  } icds_stat_t;
  typedef enum logic [1:0] {
    ICDS_SRC_PIN = 2'b01,
    ICDS_SRC_SYSREF = 2'b10
  } icds_src_t;
endpackage

// >>> icds_sync2.sv
// two-stage synchroniser bank with rising-edge pulses
`timescale 1ns/1ps
module icds_sync2 #(
  parameter int WIDTH = 2
) (
  input wire logic clk, // sample clock
  input wire logic rstn, // async reset, active low
  input wire logic [WIDTH-1:0] din, // asynchronous pins
  output logic [WIDTH-1:0] rise // one-cycle pulse per rising edge
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] last_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= '0;
      sync_r <= '0;
      last_r <= '0;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end
  // edge taken after the second flop only
  assign rise = sync_r & ~last_r;
endmodule

// >>> icds_top.sv
// input clock divider with pin or system reference alignment and duty stabilizer
`timescale 1ns/1ps
`include "icds_cfg.svh"
module icds_top #(
  parameter int RATIO_MAX = 8
) (
  input wire logic clk, // input sample clock, 25 MHz
  input wire logic rstn, // async reset, active low
  input wire logic align_pin, // external alignment pin, asynchronous
  input wire logic sysref, // link system reference, asynchronous
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  input wire logic [`ICDS_ADDR_W-1:0] reg_addr, // register offset
  input wire logic [7:0] reg_wdata, // write data
  output logic [7:0] reg_rdata, // read data, one cycle after reg_rd
  output logic conv_clk, // divided conversion clock
  output logic conv_tick, // one-cycle pulse at each conversion edge
  output logic align_done, // pulse when divider was realigned
  output logic stab_locked // stabilizer locked, registered
);
  // minimum wait rounded up to whole cycles; the upper bound only feeds a check
  localparam int RELOCK_CYC = (`ICDS_RELOCK_NS + `ICDS_CLK_NS - 1) / `ICDS_CLK_NS;
  localparam int RELOCK_MAX_CYC = `ICDS_RELOCK_MAX_NS / `ICDS_CLK_NS;
  localparam logic [7:0] RELOCK_LOAD = 8'(RELOCK_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  icds_pkg::icds_align_t align_r;
  logic [2:0] ratio_m1_r;
  logic stab_en_r;
  logic armed_r;
  logic [7:0] rdata_r;
  logic [2:0] cnt_r;
  logic conv_clk_r;
  logic conv_tick_r;
  logic align_done_r;
  logic [7:0] relock_r;
  logic locked_r;

  wire wr_align = reg_wr && (reg_addr == `ICDS_ALIGN_OFS);
  wire wr_ratio = reg_wr && (reg_addr == `ICDS_RATIO_OFS);
  wire wr_stab = reg_wr && (reg_addr == `ICDS_STAB_OFS);
  wire rd_align = reg_addr == `ICDS_ALIGN_OFS;
  wire rd_ratio = reg_addr == `ICDS_RATIO_OFS;
  wire rd_stab = reg_addr == `ICDS_STAB_OFS;
  wire rd_stat = reg_addr == `ICDS_STAT_OFS;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      align_r <= `ICDS_ALIGN_RST;
      ratio_m1_r <= 3'(`ICDS_RATIO_RST);
      stab_en_r <= 1'(`ICDS_STAB_RST);
    end else begin
      if (wr_align) begin
        align_r <= reg_wdata;
      end
      if (wr_ratio) begin
        ratio_m1_r <= reg_wdata[2:0];
      end
      if (wr_stab) begin
        stab_en_r <= reg_wdata[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alignment source and acceptance
  // both pins come from the board: two flops before the edge detect
  logic [1:0] pin_rise;
  icds_sync2 #(
    .WIDTH(2)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .din({sysref, align_pin}),
    .rise(pin_rise)
  );

  icds_pkg::icds_src_t src;
  assign src = align_r.sysref_sel ? icds_pkg::ICDS_SRC_SYSREF : icds_pkg::ICDS_SRC_PIN;
  // pin is ignored entirely while the system reference is selected
  wire align_evt = (src == icds_pkg::ICDS_SRC_SYSREF) ? pin_rise[1] : pin_rise[0];
  wire align_acc = align_evt && align_r.sync_en && (!align_r.first_only || armed_r);

  // a write in the same cycle as an accepted pulse re-arms: set wins
  wire armed_nxt = wr_align ? 1'b1 : (align_acc ? 1'b0 : armed_r);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      armed_r <= 1'b0;
    end else begin
      armed_r <= armed_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // divider
  wire [2:0] cnt_wrap = (cnt_r >= ratio_m1_r) ? 3'h0 : cnt_r + 3'h1;
  wire [2:0] cnt_nxt = align_acc ? 3'h0 : cnt_wrap;
  wire [3:0] ratio = {1'b0, ratio_m1_r} + 4'h1;
  wire [3:0] half_hi = (ratio + 4'h1) >> 1;
  // stabilizer on: high for half the period, rounded up; off: follows a single input cycle
  wire clk_nxt = stab_en_r ? ({1'b0, cnt_nxt} < half_hi) : (cnt_nxt == 3'h0);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 3'h0;
      conv_clk_r <= 1'b0;
      conv_tick_r <= 1'b0;
      align_done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      conv_clk_r <= clk_nxt;
      conv_tick_r <= (cnt_nxt == 3'h0);
      align_done_r <= align_acc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stabilizer relock timer; software polls locked before trusting samples
  wire relock_start = wr_ratio || wr_stab;
  wire [7:0] relock_nxt = relock_start ? RELOCK_LOAD :
                          (relock_r != 8'h00) ? relock_r - 8'h01 : 8'h00;
  // flag registered from the next count so the pin leaves a flop in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      relock_r <= 8'h00;
      locked_r <= 1'b1;
    end else begin
      relock_r <= relock_nxt;
      locked_r <= (relock_nxt == 8'h00);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port, unmapped offsets read zero
  icds_pkg::icds_stat_t stat;
  assign stat = '{rsv: 4'h0, locked: locked_r, armed: armed_r,
                  conv_clk: conv_clk_r, stab_en: stab_en_r};
  wire [7:0] rd_mux = rd_align ? align_r :
                      rd_ratio ? {5'h00, ratio_m1_r} :
                      rd_stab ? {7'h00, stab_en_r} :
                      rd_stat ? stat : 8'h00;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      rdata_r <= rd_mux;
    end
  end

  assign reg_rdata = rdata_r;
  assign conv_clk = conv_clk_r;
  assign conv_tick = conv_tick_r;
  assign align_done = align_done_r;
  assign stab_locked = locked_r;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_accept;
    align_acc;
  endsequence
  sequence s_restart;
    (cnt_r == 3'h0) && conv_tick && align_done;
  endsequence

  a_div_range: assert property (cnt_r <= ratio_m1_r || $past(wr_ratio))
    else $error("divider count beyond ratio");
  // a ratio write inside the window legally bends this one period
  a_div_period: assert property (disable iff (!rstn || wr_ratio)
      conv_tick && !align_done && !$past(wr_ratio) && ratio_m1_r == 3'h2
      |-> ##1 !conv_tick ##1 !conv_tick ##1 (conv_tick || align_done))
    else $error("divide by three period wrong");
  a_ratio_one: assert property ($past(rstn) && $past(ratio_m1_r) == 3'h0
      |-> conv_tick && conv_clk)
    else $error("divide by one not continuous");

  // alignment
  a_align_reset: assert property (s_accept |=> s_restart)
    else $error("accepted pulse did not restart divider");
  a_pin_ignored: assert property (align_r.sysref_sel && !pin_rise[1] |-> !align_acc)
    else $error("pin aligned while system reference selected");
  a_pin_align: assert property (!align_r.sysref_sel && align_r.sync_en
      && !align_r.first_only && pin_rise[0] |=> align_done)
    else $error("pin pulse did not align");
  a_ref_align: assert property (align_r.sysref_sel && align_r.sync_en
      && !align_r.first_only && pin_rise[1] |=> align_done)
    else $error("reference pulse did not align");
  a_every_mode: assert property (align_r.sync_en && !align_r.first_only
      && align_evt |-> align_acc)
    else $error("every-pulse mode dropped a pulse");
  a_sync_off: assert property (!align_r.sync_en |-> !align_acc)
    else $error("disabled alignment accepted a pulse");
  a_first_only: assert property (align_r.first_only && !armed_r && !wr_align |=> !align_done)
    else $error("disarmed first-pulse mode realigned");
  a_first_arm: assert property (align_r.sync_en && align_r.first_only && armed_r
      && align_evt |-> align_acc)
    else $error("armed first-pulse mode dropped a pulse");
  a_arm_clear: assert property (align_acc && !wr_align |=> !armed_r)
    else $error("accepted pulse did not disarm");
  a_arm_set: assert property (wr_align |=> armed_r)
    else $error("write did not arm realignment");
  a_read_align: assert property (reg_rd && rd_align |=> reg_rdata == $past(align_r))
    else $error("alignment register read back wrong");

  // stabilizer; four-cycle period is high for counts 0 and 1
  a_duty_half: assert property (disable iff (!rstn || wr_ratio || wr_stab)
      stab_en_r && ratio_m1_r == 3'h3 && conv_tick && !$past(wr_ratio) && !$past(wr_stab)
      |-> conv_clk ##1 conv_clk ##1 (!conv_clk || align_done))
    else $error("stabilized clock not half high");
  a_stab_off: assert property (!$past(stab_en_r) |-> conv_clk == conv_tick)
    else $error("unstabilized clock not one input cycle high");
  a_relock_time: assert property (relock_start |=> !stab_locked [*8])
    else $error("stabilizer locked too early");
  a_relock_bound: assert property ($rose(stab_locked) |-> $past(relock_r) == 8'h01
      && RELOCK_CYC <= RELOCK_MAX_CYC)
    else $error("relock count wrong");
endmodule

// >>> icds_edge_src.sv
// partner model: external alignment pin and system reference pulse source
`timescale 1ns/1ps
module icds_edge_src (
  input wire logic clk, // sample clock
  input wire logic fire_pin, // request one pin pulse
  input wire logic fire_sys, // request one reference pulse
  output logic align_pin, // alignment pin level
  output logic sysref // system reference level
);
  logic [2:0] pin_cnt_r = 3'h0;
  logic [2:0] sys_cnt_r = 3'h0;
  ////////////////////////////////////////////////////////////////////////////////
  // held four cycles so a two-flop synchroniser cannot miss the edge
  always @(posedge clk) begin
    pin_cnt_r <= fire_pin ? 3'h4 : ((pin_cnt_r != 3'h0) ? pin_cnt_r - 3'h1 : 3'h0);
    sys_cnt_r <= fire_sys ? 3'h4 : ((sys_cnt_r != 3'h0) ? sys_cnt_r - 3'h1 : 3'h0);
  end
  assign align_pin = (pin_cnt_r != 3'h0);
  assign sysref = (sys_cnt_r != 3'h0);
endmodule

// >>> test_input_clock_divider_sync.sv
// self-checking testbench of the input clock divider and alignment block
`timescale 1ns/1ps
`include "icds_cfg.svh"
module test_input_clock_divider_sync;
  logic clk = 1'b0;
  logic rstn, reg_wr, reg_rd, fire_pin, fire_sys;
  logic [9:0] reg_addr;
  logic [7:0] reg_wdata, v;
  wire logic align_pin, sysref, conv_clk, conv_tick, align_done, stab_locked;
  wire logic [7:0] reg_rdata;
  int bad_count = 0;
  int check_count = 0;
  int n_done = 0;
  int per, hi;
  always #20 clk = ~clk;
  icds_top uut (.clk(clk), .rstn(rstn), .align_pin(align_pin), .sysref(sysref),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .conv_clk(conv_clk), .conv_tick(conv_tick),
    .align_done(align_done), .stab_locked(stab_locked));
  icds_edge_src src (.clk(clk), .fire_pin(fire_pin), .fire_sys(fire_sys),
    .align_pin(align_pin), .sysref(sysref));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task rd(input logic [9:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
  // one divider period from a tick: length and conv_clk high time
  task meas();
    int k;
    k = 0;
    while (conv_tick !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    per = 0;
    hi = 0;
    do begin
      hi = hi + ((conv_clk === 1'b1) ? 1 : 0);
      per++;
      @(negedge clk);
    end while (conv_tick !== 1'b1 && per < 20);
  endtask
  task pulse(input bit sys, input int inc);
    int n0;
    n0 = n_done;
    @(negedge clk);
    fire_pin = !sys;
    fire_sys = sys;
    @(negedge clk);
    fire_pin = 1'b0;
    fire_sys = 1'b0;
    repeat (12) @(negedge clk);
    chk("align_count", 8'(inc), 8'(n_done - n0));
  endtask
  task close_out();
    if (bad_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (align_done === 1'b1) begin
      n_done <= n_done + 1;
      chk("tick_at_align", 8'h01, {7'h0, conv_tick});
    end
  end
  // whole run is under two thousand cycles
  initial begin
    #(40 * 10000);
    bad_count++;
    close_out();
  end
  initial begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 10'h000;
    reg_wdata = 8'h00;
    fire_pin = 1'b0;
    fire_sys = 1'b0;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    rd(`ICDS_ALIGN_OFS, v); chk("align_reg", `ICDS_ALIGN_RST, v);
    rd(`ICDS_RATIO_OFS, v); chk("ratio_reg", `ICDS_RATIO_RST, v);
    rd(`ICDS_STAB_OFS, v); chk("stab_reg", `ICDS_STAB_RST, v);
    wr(10'h000, 8'h55);
    rd(10'h000, v);
    chk("unmapped", 8'h00, v);
    for (int r = 1; r <= 8; r++) begin
      wr(`ICDS_RATIO_OFS, 8'(r - 1));
      @(negedge clk); chk("relock_low", 8'h00, {7'h0, stab_locked});
      repeat (40) @(negedge clk); chk("relocked", 8'h01, {7'h0, stab_locked});
      meas(); chk("period", 8'(r), 8'(per));
      chk("high_time", 8'((r + 1) / 2), 8'(hi));
    end
    wr(`ICDS_STAB_OFS, 8'h00);
    repeat (40) @(negedge clk);
    rd(`ICDS_STAT_OFS, v); chk("stat_locked", 8'h08, v & 8'h09);
    meas(); chk("high_no_stab", 8'h01, 8'(hi));
    wr(`ICDS_ALIGN_OFS, 8'h00); pulse(1'b0, 0);
    wr(`ICDS_ALIGN_OFS, 8'h01); pulse(1'b0, 1);
    pulse(1'b0, 1);
    wr(`ICDS_ALIGN_OFS, 8'h03); rd(`ICDS_STAT_OFS, v); chk("armed", 8'h04, v & 8'h04);
    pulse(1'b0, 1);
    pulse(1'b0, 0);
    rd(`ICDS_STAT_OFS, v); chk("disarmed", 8'h00, v & 8'h04);
    wr(`ICDS_ALIGN_OFS, 8'h81); pulse(1'b0, 0);
    pulse(1'b1, 1);
    wr(`ICDS_ALIGN_OFS, 8'h83); pulse(1'b1, 1);
    pulse(1'b1, 0);
    rd(`ICDS_ALIGN_OFS, v); chk("align_readback", 8'h83, v);
    close_out();
  end
endmodule
